/* hdl/ucd_alpha_decoder.sv */
// alpha-field record decoder: bytes in, 16-bit characters out
// assumes byte source and consumer run on sys_clk; in_last marks a record's final byte
module ucd_alpha_decoder
   import ucd_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic        in_valid,
   input  wire logic [7:0]  in_byte,
   input  wire logic        in_last,
   output logic             in_ready,
   output logic             out_valid,
   output logic [15:0]      out_char,
   output logic             out_is_default,
   input  wire logic        out_ready
);
   ucd_state_t   st_reg;
   ucd_state_t   st_next;
   logic         half8_reg;
   logic [7:0]   cnt_reg;
   logic [15:0]  base_reg;
   logic [7:0]   hi_reg;
   logic         skip_reg;
   logic         in_ready_reg;
   logic         out_valid_reg;
   logic [15:0]  out_char_reg;
   logic         out_def_reg;
   logic         take;
   logic         emit;
   logic [15:0]  emit_char;
   logic         emit_def;
   logic         out_valid_next;

   ucd_map_if map_bus ();

   ucd_half_page_map u_map
   (
      .m (map_bus)
   );

   assign map_bus.code_byte = in_byte;
   assign map_bus.base      = base_reg;

   assign take = clk_en && in_valid && in_ready_reg;  // [R11]

   // next state and what the accepted byte produces
   always_comb
   begin
      st_next   = st_reg;
      emit      = 1'b0;
      emit_char = ucd_def_char(in_byte);
      emit_def  = 1'b1;
      case (st_reg)
         UCD_ST_LEAD:
         begin
            // all three forms served regardless of set size  [R10]
            if (in_byte == UCD_MARK_PLAIN)
               st_next = UCD_ST_U_HI;  // [R1] [R8]
            else if (in_byte == UCD_MARK_HALF8 || in_byte == UCD_MARK_HALF16)
               st_next = UCD_ST_CNT;  // [R3] [R6] [R8]
            else
            begin
               st_next = UCD_ST_DEF;  // [R9]
               emit    = (in_byte != UCD_FILL);  // [R9]
            end
         end
         UCD_ST_DEF:
            emit = (in_byte != UCD_FILL);
         UCD_ST_U_HI:
            st_next = UCD_ST_U_LO;
         UCD_ST_U_LO:
         begin
            st_next   = UCD_ST_U_HI;
            emit      = ({hi_reg, in_byte} != UCD_FILL_PAIR) && !skip_reg;  // [R2]
            emit_char = {hi_reg, in_byte};  // [R1]
            emit_def  = 1'b0;
         end
         UCD_ST_CNT:
            st_next = UCD_ST_B1;
         UCD_ST_B1:
            st_next = half8_reg ? UCD_ST_BODY : UCD_ST_B2;  // [R3] [R6]
         UCD_ST_B2:
            st_next = UCD_ST_BODY;
         UCD_ST_BODY:
         begin
            emit      = (cnt_reg != UCD_CNT_ZERO);  // [R5]
            emit_char = map_bus.ch;  // [R4] [R7]
            emit_def  = map_bus.is_def;
         end
         default:
            st_next = UCD_ST_LEAD;
      endcase
      if (in_last)
         st_next = UCD_ST_LEAD;  // [R8]
   end

   // record state
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         st_reg <= UCD_ST_LEAD;
      else if (take)
         st_reg <= st_next;
   end

   // form chosen once per record from the lead byte
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         half8_reg <= 1'b0;
      else if (take && st_reg == UCD_ST_LEAD)
         half8_reg <= (in_byte == UCD_MARK_HALF8);  // [R8]
   end

   // plain form: once a filler pair is seen the rest is filler
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         skip_reg <= 1'b0;
      else if (take)
      begin
         if (in_last || st_reg == UCD_ST_LEAD)
            skip_reg <= 1'b0;
         else if (st_reg == UCD_ST_U_LO && {hi_reg, in_byte} == UCD_FILL_PAIR)
            skip_reg <= 1'b1;  // [R2]
      end
   end

   // upper half of a plain character
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         hi_reg <= 8'h00;
      else if (take && st_reg == UCD_ST_U_HI)
         hi_reg <= in_byte;  // [R1]
   end

   // character count of the counted forms
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_reg <= 8'h00;
      else if (take && st_reg == UCD_ST_CNT)
         cnt_reg <= in_byte;  // [R3] [R6]
      else if (take && st_reg == UCD_ST_BODY && cnt_reg != UCD_CNT_ZERO)
         cnt_reg <= cnt_reg - UCD_CNT_ONE;  // [R5]
   end

   // base pointer
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         base_reg <= 16'h0000;
      else if (take && st_reg == UCD_ST_B1)
      begin
         if (half8_reg)
            base_reg <= {1'b0, in_byte, 7'h00};  // [R3]
         else
            base_reg <= {in_byte, 8'h00};  // [R6]
      end
      else if (take && st_reg == UCD_ST_B2)
         base_reg <= {base_reg[15:8], in_byte};  // [R6]
   end

   // output holding register and byte-side ready
   always_comb
   begin
      out_valid_next = out_valid_reg && !out_ready;
      if (take && emit)
         out_valid_next = 1'b1;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         out_valid_reg <= 1'b0;
         out_char_reg  <= 16'h0000;
         out_def_reg   <= 1'b0;
         in_ready_reg  <= 1'b0;
      end
      else if (clk_en)
      begin
         out_valid_reg <= out_valid_next;  // [R11]
         in_ready_reg  <= !out_valid_next;  // [R11]
         if (take && emit)
         begin
            out_char_reg <= emit_char;
            out_def_reg  <= emit_def;
         end
      end
   end

   assign in_ready       = in_ready_reg;
   assign out_valid      = out_valid_reg;
   assign out_char       = out_char_reg;
   assign out_is_default = out_def_reg;

   plain_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_b)  // [R1]
      take && st_reg == UCD_ST_U_LO && !skip_reg && {hi_reg, in_byte} != UCD_FILL_PAIR
      |=> out_valid_reg && !out_def_reg && out_char_reg == {$past(hi_reg), $past(in_byte)})
      else $error("plain pair not emitted as upper then lower byte");

   filler_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)  // [R2]
      take && st_reg == UCD_ST_U_LO && {hi_reg, in_byte} == UCD_FILL_PAIR && !out_valid_reg
      |=> !out_valid_reg)
      else $error("filler pair produced a character");

   half_base_a: assert property (@(posedge sys_clk) disable iff (!rst_b)  // [R3]
      take && st_reg == UCD_ST_B1 && half8_reg
      |=> base_reg == {1'b0, $past(in_byte), 7'h00})
      else $error("half-page base pointer wrong");

   body_map_a: assert property (@(posedge sys_clk) disable iff (!rst_b)  // [R4] [R7]
      take && st_reg == UCD_ST_BODY && cnt_reg != UCD_CNT_ZERO && in_byte[UCD_TOP_BIT]
      |=> out_valid_reg && !out_def_reg
          && out_char_reg == $past(base_reg) + {9'h000, $past(in_byte[6:0])})
      else $error("body byte offset not added to base");

   count_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)  // [R5]
      take && st_reg == UCD_ST_BODY && cnt_reg == UCD_CNT_ZERO && !out_valid_reg
      |=> !out_valid_reg)
      else $error("character emitted beyond the count");

   full_base_a: assert property (@(posedge sys_clk) disable iff (!rst_b)  // [R6]
      take && st_reg == UCD_ST_B2
      |=> base_reg == {$past(base_reg[15:8]), $past(in_byte)})
      else $error("full base pointer wrong");

   one_form_a: assert property (@(posedge sys_clk) disable iff (!rst_b)  // [R8]
      st_reg != UCD_ST_LEAD ##1 st_reg != UCD_ST_LEAD |-> $stable(half8_reg))
      else $error("coding changed within a record");

   default_lead_a: assert property (@(posedge sys_clk) disable iff (!rst_b)  // [R9]
      take && st_reg == UCD_ST_LEAD && in_byte != UCD_FILL && in_byte != UCD_MARK_PLAIN
      && in_byte != UCD_MARK_HALF8 && in_byte != UCD_MARK_HALF16
      |=> out_valid_reg && out_def_reg && out_char_reg == {9'h000, $past(in_byte[6:0])})
      else $error("plain lead byte not emitted as default text");

   hold_out_a: assert property (@(posedge sys_clk) disable iff (!rst_b)  // [R11]
      out_valid_reg && !out_ready
      |=> out_valid_reg && !in_ready_reg && $stable(out_char_reg))
      else $error("held character dropped or changed");
endmodule

/* hdl/ucd_half_page_map.sv */
// maps one half-page body byte to a default character or a code point
// assumes the base pointer is stable while the byte is presented
module ucd_half_page_map
   import ucd_pkg::*;
(
   ucd_map_if.mapper m
);
   always_comb
   begin
      if (m.code_byte[UCD_TOP_BIT])
      begin
         m.ch     = m.base + {9'h000, m.code_byte[6:0]};  // [R4] [R7]
         m.is_def = 1'b0;
      end
      else
      begin
         m.ch     = ucd_def_char(m.code_byte);  // [R4] [R7]
         m.is_def = 1'b1;
      end
   end
endmodule

/* hdl/ucd_map_if.sv */
// carries one body byte and the base pointer to the mapper and the result back
// assumes the mapper is purely combinational
interface ucd_map_if;
   logic [7:0]  code_byte;
   logic [15:0] base;
   logic [15:0] ch;
   logic        is_def;

   modport mapper
   (
      input  code_byte,
      input  base,
      output ch,
      output is_def
   );
   modport user
   (
      output code_byte,
      output base,
      input  ch,
      input  is_def
   );
endinterface

/* hdl/ucd_pkg.sv */
// constants, states and codes for the alpha-field character decoder
// assumes a single clock domain and a byte source that marks each record's last byte
// Contract
// [R1] marker 80: byte pairs, earlier byte upper
// [R2] filler FF pairs in plain form emit nothing
// [R3] marker 81: count, base bits 15..8; the code loads the byte into base bits 14..7
// [R4] 81 body: clear top default, set adds
// [R5] counted forms stop after count; FF counts
// [R6] marker 82: count, full 16-bit base
// [R7] 82 body: clear top default, set adds
// [R8] one coding per record, chosen by lead
// [R9] any other lead starts default text
// [R10] all three forms served, any set size
// [R11] byte handshake in, char plus flag out
package ucd_pkg;
   localparam logic [7:0] UCD_MARK_PLAIN  = 8'h80;
   localparam logic [7:0] UCD_MARK_HALF8  = 8'h81;
   localparam logic [7:0] UCD_MARK_HALF16 = 8'h82;
   localparam logic [7:0] UCD_FILL        = 8'hFF;
   localparam logic [15:0] UCD_FILL_PAIR  = 16'hFFFF;
   localparam int          UCD_TOP_BIT    = 7;
   localparam logic [7:0] UCD_CNT_ONE     = 8'h01;
   localparam logic [7:0] UCD_CNT_ZERO    = 8'h00;

   typedef enum logic [2:0]
   {
      UCD_ST_LEAD = 3'b000,
      UCD_ST_DEF  = 3'b001,
      UCD_ST_U_HI = 3'b010,
      UCD_ST_U_LO = 3'b011,
      UCD_ST_CNT  = 3'b100,
      UCD_ST_B1   = 3'b101,
      UCD_ST_B2   = 3'b110,
      UCD_ST_BODY = 3'b111
   } ucd_state_t;

   // default-alphabet character from the low seven bits
   function automatic logic [15:0] ucd_def_char(input logic [7:0] b);
      ucd_def_char = {9'h000, b[6:0]};
   endfunction
endpackage

/* verification/tb.sv */
// testbench: record stimulus, expected-character queue and output monitor
// assumes the byte source model and the decoder share sys_clk
module tb
   import ucd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        clk_en = 1'b1;
   logic        out_ready = 1'b0;
   logic        in_ready;
   logic        in_valid;
   logic        in_last;
   logic [7:0]  in_byte;
   logic        out_valid;
   logic        out_is_default;
   logic [15:0] out_char;
   logic [16:0] exp_q[$];
   int          errors = 0;
   int          n_compared = 0;
   int          w;

   always #2.5 sys_clk = ~sys_clk;

   ucd_byte_source u_src (.sys_clk(sys_clk), .clk_en(clk_en), .in_ready(in_ready),
      .in_valid(in_valid), .in_byte(in_byte), .in_last(in_last));
   ucd_alpha_decoder u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
      .in_valid(in_valid), .in_byte(in_byte), .in_last(in_last), .in_ready(in_ready),
      .out_valid(out_valid), .out_char(out_char), .out_is_default(out_is_default),
      .out_ready(out_ready));

   task check(input logic [16:0] seen, input logic [16:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_sim;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // work out the characters of one record, then hand its bytes to the source
   task automatic rec(input logic [7:0] b[$]);
      int          i;
      int          k;
      int          s;
      logic [15:0] base;
      s = b.size();
      if (b[0] == UCD_MARK_PLAIN)
         for (i = 1; i + 1 < s && {b[i], b[i+1]} != UCD_FILL_PAIR; i += 2)
            exp_q.push_back({1'b0, b[i], b[i+1]});
      else if (b[0] == UCD_MARK_HALF8 || b[0] == UCD_MARK_HALF16)
      begin
         base = (b[0] == UCD_MARK_HALF8) ? {1'b0, b[2], 7'h00} : {b[2], b[3]};
         i = (b[0] == UCD_MARK_HALF8) ? 3 : 4;
         for (k = 0; k < b[1] && i + k < s; k++)
            exp_q.push_back(b[i+k][7] ? {1'b0, base + b[i+k][6:0]}
                                      : {1'b1, 9'h000, b[i+k][6:0]});
      end
      else
         foreach (b[j])
            if (b[j] != UCD_FILL)
               exp_q.push_back({1'b1, 9'h000, b[j][6:0]});
      for (i = 0; i < s; i++)
         u_src.q.push_back({i == s - 1, b[i]});
   endtask

   // each call builds a fresh record
   task automatic rand_rec;
      logic [7:0] b[$];
      int         m;
      int         n;
      m = $urandom_range(3);
      n = $urandom_range(8);
      b.push_back(m == 3 ? 8'h41 : 8'h80 + m[7:0]);
      if (m == 1 || m == 2)
         b.push_back(n[7:0]);
      repeat (m)
         b.push_back(8'($urandom));
      repeat (n + $urandom_range(2))
         b.push_back(8'($urandom));
      rec(b);
   endtask

   always @(negedge sys_clk)
   begin
      out_ready <= $urandom_range(3) != 0;
      clk_en <= $urandom_range(7) != 0;
   end

   always @(posedge sys_clk)
      if (rst_b && clk_en && out_valid && out_ready)
         check({out_is_default, out_char}, exp_q.size() ? exp_q.pop_front() : 17'hX);

   initial
   begin
      #200000;
      errors++;
      end_sim;
   end

   initial
   begin
      void'($urandom(49381));
      repeat (5) @(negedge sys_clk);
      rst_b = 1'b1;
      rec('{8'h80, 8'h12, 8'h34, 8'hAB, 8'hCD, 8'hFF, 8'hFF, 8'h00, 8'h41});
      rec('{8'h80, 8'h00, 8'h41, 8'h77});
      rec('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h58, 8'hFF, 8'hFF, 8'hFF});
      rec('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31, 8'h41});
      rec('{8'h48, 8'h69, 8'hFF, 8'hFF, 8'h21});
      rec('{8'h81, 8'h00, 8'h13, 8'h41});
      rec('{8'hFF, 8'h45, 8'hFF, 8'h46});
      repeat (40) rand_rec();
      for (w = 0; w < 20000 && (exp_q.size() > 0 || u_src.q.size() > 0); w++)
         @(negedge sys_clk);
      repeat (20) @(negedge sys_clk);
      check(17'(exp_q.size()), 17'h00000);
      end_sim;
   end
endmodule

/* verification/ucd_byte_source.sv */
// byte source model: replays queued record bytes into the decoder
// assumes the bench loads q with {last, byte}; drives on the falling edge
module ucd_byte_source
(
   input  wire logic       sys_clk,
   input  wire logic       clk_en,
   input  wire logic       in_ready,
   output logic            in_valid,
   output logic [7:0]      in_byte,
   output logic            in_last
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] q[$];
   logic       took;
   initial
   begin
      in_valid = 1'b0;
      in_byte  = 8'h00;
      in_last  = 1'b0;
      took     = 1'b0;
   end
   always @(posedge sys_clk)
      took <= in_valid && in_ready && clk_en;
   // hold a byte until taken, then offer the next one or idle with toggling data
   always @(negedge sys_clk)
      if (!in_valid || took)
      begin
         if (q.size() > 0 && $urandom_range(3) != 0)
         begin
            {in_last, in_byte} = q.pop_front();
            in_valid = 1'b1;
         end
         else
         begin
            in_valid = 1'b0;
            in_byte  = ~in_byte;
            in_last  = ~in_last;
         end
      end
endmodule
